// ### pir_pkg.sv
// pir_pkg: constants for the peripheral interrupt routing block
// assumes a 32-bit apb register bus and a single system clock
package pir_pkg;
  localparam int PIR_LINES = 32;
  localparam int PIR_USED_LINES = 25;
  localparam int PIR_PRIO_W = 2;
  localparam int PIR_LINE_W = 5;
  localparam int PIR_SRC_W = 8;
  // controller line assignment
  localparam int LINE_POWER_MANAGER = 0;
  localparam int LINE_SYSTEM_CONTROL_UNIT = 1;
  localparam int LINE_WATCHDOG_UNIT = 2;
  localparam int LINE_RTC = 3;
  localparam int LINE_EXTERNAL_IRQ_UNIT = 4;
  localparam int LINE_NONVOLATILE_MEM_CTRL = 5;
  localparam int LINE_EVENT_SYSTEM = 6;
  localparam int LINE_SERIAL_COMM_BASE = 7;
  localparam int NUM_SERIAL_COMM = 6;
  localparam int LINE_TIMER_COUNTER_BASE = 13;
  localparam int NUM_TIMER_COUNTER = 8;
  localparam int LINE_ADC = 21;
  localparam int LINE_ANALOG_COMPARATOR = 22;
  localparam int LINE_DAC = 23;
  localparam int LINE_TOUCH_CONTROLLER = 24;
  // controller register space
  localparam logic [31:0] CTRL_BASE_ADDR = 32'hE000E100;
  localparam logic [11:0] OFS_LINE_ENABLE_SET = 12'h000;
  localparam logic [11:0] OFS_LINE_ENABLE_CLEAR = 12'h080;
  localparam logic [11:0] OFS_PENDING_SET = 12'h100;
  localparam logic [11:0] OFS_PENDING_CLEAR = 12'h180;
  localparam logic [11:0] OFS_PRIO_BANK = 12'h300;
  localparam logic [11:0] OFS_ACTIVE = 12'h400;
  localparam int PRIO_REGS = 8;
  localparam int PRIO_FIELD_LSB = 6;
  // per-source register window, offset 0x800
  localparam logic [11:0] OFS_SRC_BASE = 12'h800;
  localparam logic [11:0] OFS_SRC_STRIDE = 12'h010;
  localparam logic [3:0] SRC_ENCLR = 4'h0;
  localparam logic [3:0] SRC_ENSET = 4'h4;
  localparam logic [3:0] SRC_FLAG = 4'h8;
  localparam logic [31:0] RESET_ZERO = 32'h00000000;
endpackage : pir_pkg

// ### pir_src_if.sv
// pir_src_if: register access and request path of one peripheral source
// assumes the top decodes the apb and the source register answers
`timescale 1ns/1ps
interface pir_src_if;
  import pir_pkg::*;
  logic wr_clr;
  logic wr_set;
  logic wr_flag;
  logic [PIR_SRC_W-1:0] wdata;
  logic [PIR_SRC_W-1:0] enable;
  logic [PIR_SRC_W-1:0] flags;
  logic req;
  modport ctrl (output wr_clr, wr_set, wr_flag, wdata,
                input enable, flags, req);
  modport src (input wr_clr, wr_set, wr_flag, wdata,
               output enable, flags, req);
endinterface : pir_src_if

// ### pir_src_regs.sv
// pir_src_regs: flags, enables and gated request of one peripheral
// assumes condition pulses arrive on pclk from peripheral logic
`timescale 1ns/1ps
module pir_src_regs
  import pir_pkg::*;
#(
  parameter int W = PIR_SRC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // interrupt conditions
  input wire logic [W-1:0] cond,
  // register side
  pir_src_if.src bus
);
  logic [W-1:0] flag_q;
  logic [W-1:0] en_q;

  // flag sets regardless of enable; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~({W{bus.wr_flag}} & bus.wdata)) | cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (bus.wr_set) begin
      en_q <= en_q | bus.wdata;
    end else if (bus.wr_clr) begin
      en_q <= en_q & ~bus.wdata;
    end
  end

  assign bus.enable = en_q;
  assign bus.flags = flag_q;
  assign bus.req = |(flag_q & en_q);
endmodule : pir_src_regs

// ### pir_routing.sv
// pir_routing: peripheral interrupt routing and nested vectored controller
// assumes an apb master on pclk and peripheral conditions on pclk
// Operation
// - 32 request lines, four priority levels
// - each used line has one source
// - condition sets flag even when disabled
// - writing one to enable-set enables
// - writing one to enable-clear disables
// - request needs flag and its enable
// - source requests ORed into one line
// - request sets pending; software sets/clears pending
// - active only when line enabled
// - eight priority registers hold line priorities
// - power, system control, watchdog, rtc on 0-3
// - external unit line 4, nmi separate
// - nvm controller 5, event system 6
// - serial units on lines 7 to 12
// - timer counters on lines 13 to 20
// - adc 21, comparator 22, dac 23, touch 24
// - register space starts at 0xE000E100
`timescale 1ns/1ps
module pir_routing
  import pir_pkg::*;
#(
  parameter int SRC_W = PIR_SRC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral interrupt conditions, one vector per used line
  input wire logic [PIR_USED_LINES*SRC_W-1:0] src_cond,
  input wire logic ext_nmi_cond,
  // processor side
  output logic irq_valid,
  output logic [PIR_LINE_W-1:0] irq_line,
  output logic [PIR_PRIO_W-1:0] irq_prio,
  output logic nmi_req
);
  logic [PIR_LINES-1:0] line_req;
  logic [PIR_LINES-1:0] line_en_q;
  logic [PIR_LINES-1:0] pend_q;
  logic [PIR_PRIO_W-1:0] prio_q [PIR_LINES];
  logic [PIR_USED_LINES-1:0][SRC_W-1:0] src_en;
  logic [PIR_USED_LINES-1:0][SRC_W-1:0] src_flag;
  logic [31:0] prdata_q;
  logic nmi_q;
  logic acc;
  logic wr;
  logic in_ctrl;
  logic [11:0] ofs;
  logic ofs_src;
  logic [11:0] src_rel;
  logic [4:0] src_idx;
  logic [3:0] src_reg;
  logic src_hit;
  logic [31:0] rd_d;
  logic err_d;

  // controller window at the fixed base address
  assign in_ctrl = (paddr[31:12] == CTRL_BASE_ADDR[31:12]) &&
                   (paddr[11:0] >= CTRL_BASE_ADDR[11:0]);
  assign ofs = paddr[11:0] - CTRL_BASE_ADDR[11:0];
  assign acc = psel && penable;
  assign wr = acc && pwrite && in_ctrl && !err_d;
  assign ofs_src = (ofs >= OFS_SRC_BASE);
  assign src_rel = ofs - OFS_SRC_BASE;
  assign src_idx = src_rel[8:4];
  assign src_reg = src_rel[3:0];
  assign src_hit = ofs_src && (src_rel[11:9] == 3'h0) &&
                   (src_idx < 5'(PIR_USED_LINES)) &&
                   (src_reg == SRC_ENCLR || src_reg == SRC_ENSET ||
                    src_reg == SRC_FLAG);

  function automatic logic is_prio(input logic [11:0] o);
    return (o >= OFS_PRIO_BANK) &&
           (o < OFS_PRIO_BANK + 12'(PRIO_REGS * 4)) && (o[1:0] == 2'h0);
  endfunction : is_prio

  // one dedicated source per used line, mapped in line order
  genvar g;
  generate
    for (g = 0; g < PIR_USED_LINES; g++) begin : g_src
      pir_src_if sif ();
      assign sif.wr_clr = wr && src_hit && (src_idx == 5'(g)) &&
                          (src_reg == SRC_ENCLR);
      assign sif.wr_set = wr && src_hit && (src_idx == 5'(g)) &&
                          (src_reg == SRC_ENSET);
      assign sif.wr_flag = wr && src_hit && (src_idx == 5'(g)) &&
                           (src_reg == SRC_FLAG);
      assign sif.wdata = pwdata[SRC_W-1:0];
      pir_src_regs #(.W(SRC_W)) u_src (
        .pclk(pclk),
        .presetn(presetn),
        .cond(src_cond[g*SRC_W +: SRC_W]),
        .bus(sif)
      );
      assign line_req[g] = sif.req;
      assign src_en[g] = sif.enable;
      assign src_flag[g] = sif.flags;
    end
    for (g = PIR_USED_LINES; g < PIR_LINES; g++) begin : g_unused
      assign line_req[g] = 1'b0;
    end
  endgenerate

  // non-maskable request bypasses the controller lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= ext_nmi_cond;
    end
  end
  assign nmi_req = nmi_q;

  // line enable set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_en_q <= '0;
    end else if (wr && ofs == OFS_LINE_ENABLE_SET) begin
      line_en_q <= line_en_q | pwdata;
    end else if (wr && ofs == OFS_LINE_ENABLE_CLEAR) begin
      line_en_q <= line_en_q & ~pwdata;
    end
  end

  // pending: hardware request wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= ((pend_q
                  | ({PIR_LINES{wr && ofs == OFS_PENDING_SET}} & pwdata))
                 & ~({PIR_LINES{wr && ofs == OFS_PENDING_CLEAR}} & pwdata))
                | line_req;
    end
  end

  // priority bank, four 2-bit fields per word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PIR_LINES; i++) begin
        prio_q[i] <= '0;
      end
    end else if (wr && is_prio(ofs)) begin
      for (int b = 0; b < 4; b++) begin
        prio_q[{ofs[4:2], 2'(b)}] <=
          pwdata[8*b+PRIO_FIELD_LSB +: PIR_PRIO_W];
      end
    end
  end

  // arbitration: lower value is higher priority, low line on ties
  logic best_v;
  logic [PIR_LINE_W-1:0] best_l;
  logic [PIR_PRIO_W-1:0] best_p;
  always_comb begin
    best_v = 1'b0;
    best_l = '0;
    best_p = '1;
    for (int i = 0; i < PIR_LINES; i++) begin
      if (pend_q[i] && line_en_q[i] && (!best_v || prio_q[i] < best_p)) begin
        best_v = 1'b1;
        best_l = PIR_LINE_W'(i);
        best_p = prio_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_valid <= 1'b0;
      irq_line <= '0;
      irq_prio <= '0;
    end else begin
      irq_valid <= best_v;
      irq_line <= best_l;
      irq_prio <= best_v ? best_p : '0;
    end
  end

  // read mux and error decode
  always_comb begin
    rd_d = RESET_ZERO;
    err_d = 1'b0;
    if (!in_ctrl) begin
      err_d = 1'b1;
    end else if (ofs == OFS_LINE_ENABLE_SET ||
                 ofs == OFS_LINE_ENABLE_CLEAR) begin
      rd_d = line_en_q;
    end else if (ofs == OFS_PENDING_SET || ofs == OFS_PENDING_CLEAR) begin
      rd_d = pend_q;
    end else if (is_prio(ofs)) begin
      for (int b = 0; b < 4; b++) begin
        rd_d[8*b+PRIO_FIELD_LSB +: PIR_PRIO_W] = prio_q[{ofs[4:2], 2'(b)}];
      end
    end else if (ofs == OFS_ACTIVE) begin
      rd_d = {best_v, 21'h0, best_p, 3'h0, best_l};
    end else if (src_hit) begin
      if (src_reg == SRC_FLAG) begin
        rd_d[SRC_W-1:0] = src_flag[src_idx];
      end else begin
        rd_d[SRC_W-1:0] = src_en[src_idx];
      end
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= RESET_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = acc && err_d;
endmodule : pir_routing

// ### pir_routing_props.sv
// checker: port-level properties of pir_routing
// assumes it is bound onto pir_routing
`timescale 1ns/1ps
module pir_routing_props
  import pir_pkg::*;
#(
  parameter int SRC_W = PIR_SRC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sources and processor side
  input wire logic [PIR_USED_LINES*SRC_W-1:0] src_cond,
  input wire logic ext_nmi_cond,
  input wire logic irq_valid,
  input wire logic [PIR_LINE_W-1:0] irq_line,
  input wire logic [PIR_PRIO_W-1:0] irq_prio,
  input wire logic nmi_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  a_nmi_delay: assert property (
    1'b1 |=> nmi_req == $past(ext_nmi_cond)) else $error("nmi late");
  a_ready_high: assert property (
    acc |-> pready) else $error("pready low");
  a_prio_idle: assert property (
    !irq_valid |-> irq_prio == '0) else $error("prio not zero");
  a_err_below: assert property (
    acc && paddr < CTRL_BASE_ADDR |-> pslverr) else $error("no err low");
  a_err_above: assert property (
    acc && paddr > 32'hE000EFFF |-> pslverr) else $error("no err high");
  a_base_ok: assert property (
    acc && paddr == CTRL_BASE_ADDR |-> !pslverr) else $error("base err");
  a_rd_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("rdata moved");
  a_clr_drop: assert property (
    acc && pwrite && pwdata == '1 &&
    paddr == CTRL_BASE_ADDR + 32'(OFS_LINE_ENABLE_CLEAR)
    |-> ##[1:2] !irq_valid) else $error("valid stuck");
endmodule : pir_routing_props
bind pir_routing pir_routing_props #(.SRC_W(SRC_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_cond(src_cond),
  .ext_nmi_cond(ext_nmi_cond), .irq_valid(irq_valid),
  .irq_line(irq_line), .irq_prio(irq_prio), .nmi_req(nmi_req));

// ### pir_src_model.sv
// model: peripherals raising one-cycle condition pulses
// assumes the bench requests pulses on pclk
`timescale 1ns/1ps
module pir_src_model
  import pir_pkg::*;
(
  // clock
  input wire logic pclk,
  // bench requests
  input wire logic fire,
  input wire logic [4:0] fire_line,
  input wire logic [2:0] fire_bit,
  input wire logic nmi_fire,
  // toward the block
  output logic [PIR_USED_LINES*PIR_SRC_W-1:0] src_cond,
  output logic ext_nmi_cond
);
  always_ff @(posedge pclk) begin
    src_cond <= '0;
    if (fire) src_cond[fire_line*PIR_SRC_W+fire_bit] <= 1'b1;
    ext_nmi_cond <= nmi_fire;
  end
endmodule : pir_src_model

// ### pir_routing_tb.sv
// testbench: apb register and interrupt routing tests
// assumes pir_src_model stands in for the peripherals
`timescale 1ns/1ps
module pir_routing_tb;
  import pir_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fire = 1'b0, nmi_fire = 1'b0, e;
  logic pready, pslverr, irq_valid, nmi_req, ext_nmi_cond;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic [4:0] fire_line = '0, irq_line;
  logic [2:0] fire_bit = '0;
  logic [1:0] irq_prio;
  logic [PIR_USED_LINES*PIR_SRC_W-1:0] src_cond;
  int error_cnt = 0, comparisons = 0;
  always #12.5 pclk = ~pclk;
  pir_src_model u_src (.pclk(pclk), .fire(fire), .fire_line(fire_line),
    .fire_bit(fire_bit), .nmi_fire(nmi_fire), .src_cond(src_cond),
    .ext_nmi_cond(ext_nmi_cond));
  pir_routing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_cond(src_cond), .ext_nmi_cond(ext_nmi_cond),
    .irq_valid(irq_valid), .irq_line(irq_line), .irq_prio(irq_prio),
    .nmi_req(nmi_req));
  function automatic logic [31:0] ca(logic [11:0] o);
    return CTRL_BASE_ADDR + 32'(o);
  endfunction : ca
  function automatic logic [31:0] sa(int g, logic [3:0] o);
    return ca(OFS_SRC_BASE) + 32'(g) * 32'(OFS_SRC_STRIDE) + 32'(o);
  endfunction : sa
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(logic [31:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [31:0] a, logic [31:0] x);
    apb(1'b0, a, '0);
    chk(r, x);
  endtask : rd
  task automatic pulse(int g, int b);
    @(posedge pclk);
    fire <= 1'b1;
    fire_line <= 5'(g);
    fire_bit <= 3'(b);
    @(posedge pclk);
    fire <= 1'b0;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask : pulse
  task automatic wrap_up;
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ca(OFS_LINE_ENABLE_SET), RESET_ZERO);
    wr(sa(13, SRC_ENSET), 32'h5);
    wr(sa(13, SRC_ENSET), 32'h2);
    rd(sa(13, SRC_ENCLR), 32'h7);
    wr(sa(13, SRC_ENCLR), 32'h1);
    rd(sa(13, SRC_ENSET), 32'h6);
    wr(sa(13, SRC_ENCLR), 32'hFF);
    $display("test enables done");
    wr(ca(OFS_LINE_ENABLE_SET), 32'h80);
    pulse(7, 2);
    chk(32'(irq_valid), 32'h0);
    rd(ca(OFS_PENDING_SET), RESET_ZERO);
    rd(sa(7, SRC_FLAG), 32'h4);
    wr(sa(7, SRC_FLAG), 32'h0);
    rd(sa(7, SRC_FLAG), 32'h4);
    wr(sa(7, SRC_FLAG), 32'h4);
    rd(sa(7, SRC_FLAG), 32'h0);
    wr(ca(OFS_LINE_ENABLE_CLEAR), 32'h80);
    $display("test flags done");
    for (int g = 0; g < PIR_USED_LINES; g++) begin
      wr(ca(OFS_LINE_ENABLE_SET), 32'h1 << g);
      wr(sa(g, SRC_ENSET), 32'h1 << (g % 8));
      pulse(g, g % 8);
      chk(32'(irq_valid), 32'h1);
      chk(32'(irq_line), 32'(g));
      rd(ca(OFS_PENDING_SET), 32'h1 << g);
      wr(sa(g, SRC_FLAG), 32'hFF);
      wr(sa(g, SRC_ENCLR), 32'hFF);
      wr(ca(OFS_PENDING_CLEAR), '1);
      wr(ca(OFS_LINE_ENABLE_CLEAR), '1);
    end
    $display("test line map done");
    wr(ca(OFS_LINE_ENABLE_SET), 32'h208);
    wr(ca(OFS_PRIO_BANK), 32'h80000000);
    wr(ca(OFS_PRIO_BANK + 12'h8), 32'h00004000);
    wr(ca(OFS_PENDING_SET), 32'h208);
    rd(ca(OFS_ACTIVE), 32'h80000109);
    @(negedge pclk);
    chk(32'(irq_prio), 32'h1);
    wr(ca(OFS_PRIO_BANK + 12'h8), 32'h00008000);
    rd(ca(OFS_ACTIVE), 32'h80000203);
    @(negedge pclk);
    chk(32'(irq_prio), 32'h2);
    wr(ca(OFS_PENDING_CLEAR), '1);
    wr(ca(OFS_LINE_ENABLE_CLEAR), '1);
    $display("test priority done");
    apb(1'b0, 32'hE000E0FC, '0);
    chk(32'(e), 32'h1);
    apb(1'b0, 32'hE000F000, '0);
    chk(32'(e), 32'h1);
    apb(1'b0, ca(12'h200), '0);
    chk(32'(e), 32'h1);
    $display("test decode done");
    @(posedge pclk);
    nmi_fire <= 1'b1;
    @(posedge pclk);
    nmi_fire <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({nmi_req, irq_valid}), 32'h2);
    $display("test nmi done");
    wrap_up;
  end
endmodule : pir_routing_tb
